// ### rtl/reader_command_dispatcher.sv
// Command state machine, FIFO and test registers of the reader core.
`timescale 1ns/100ps
module reader_command_dispatcher (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // RF datapath
  output logic      [7:0]  rf_tx_byte,
  output logic             rf_tx_strobe,
  output logic             rf_rx_enable,
  input  wire logic [7:0]  rf_rx_byte,
  input  wire logic        rf_rx_valid,
  input  wire logic        rf_rx_end,
  // Authentication engine
  output logic             card_auth_active,
  input  wire logic        card_auth_done,
  // Analog test pins
  input  wire logic [3:0]  adc_i_pin,
  input  wire logic [3:0]  adc_q_pin,
  output logic      [5:0]  probe_dac_first_value,
  output logic      [5:0]  probe_dac_second_value,
  output logic             probe_pin_first_dac_route,
  output logic             probe_pin_second_dac_route,
  output logic             power_down
);

  // ==========================================================
  // Register storage.
  dispatch_pkg::op_state_t state_reg;
  logic [7:0]  fifo_mem [0:dispatch_pkg::FIFO_DEPTH-1];
  logic [7:0]  buffer_mem [0:24];
  logic [5:0]  wr_ptr_reg;
  logic [5:0]  rd_ptr_reg;
  logic [6:0]  count_reg;
  logic [4:0]  idx_reg;
  logic [15:0] checksum_reg;
  logic [15:0] lfsr_reg;
  logic        power_down_reg;
  logic        kick_reg;
  logic [2:0]  last_bits_reg;
  logic [3:0]  self_test_reg;
  logic [7:0]  probe_sel_reg;
  logic [5:0]  dac_one_reg;
  logic [5:0]  dac_two_reg;
  logic [7:0]  factory_reg [0:3];
  logic [7:0]  adc_meta_reg;
  logic [7:0]  adc_sync_reg;
  logic        soft_reset_reg;
  logic        clr;

  // Soft reset clears everything but the buffer, the FIFO storage, the random generator, the ADC snapshot and the bus pipeline.
  assign clr = reset | soft_reset_reg;

  // ==========================================================
  // AHB-Lite slave: writes commit at end of data phase, reads
  // take one wait state so they see a preceding write.
  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic [5:0]  aidx_reg;
  logic        amapped_reg;
  logic        accept;
  logic        host_wr;
  logic        host_rd;
  logic [3:0]  new_cmd;

  assign accept  = hsel & htrans[1] & hready;
  assign host_wr = wr_pend_reg & amapped_reg;
  assign host_rd = rd_pend_reg & amapped_reg;
  assign new_cmd = hwdata[3:0];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      aidx_reg    <= 6'h00;
      amapped_reg <= 1'b0;
      hreadyout   <= 1'b1;
    end else begin
      wr_pend_reg <= accept & hwrite;
      rd_pend_reg <= accept & ~hwrite;
      hreadyout   <= ~(accept & ~hwrite);
      if (accept) begin
        aidx_reg    <= haddr[7:2];
        amapped_reg <= (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'b00);
      end
    end
  end

  assign hresp = 1'b0;

  function automatic logic [3:0] code_of(dispatch_pkg::op_state_t s);
    case (s)
      dispatch_pkg::ST_MEM_IN,
      dispatch_pkg::ST_MEM_OUT:   code_of = dispatch_pkg::OP_MEM;
      dispatch_pkg::ST_RANDOM:    code_of = dispatch_pkg::OP_RANDOM;
      dispatch_pkg::ST_CHECKSUM,
      dispatch_pkg::ST_SELF_TEST: code_of = dispatch_pkg::OP_CHECKSUM;
      dispatch_pkg::ST_TRANSMIT:  code_of = dispatch_pkg::OP_TRANSMIT;
      dispatch_pkg::ST_RECEIVE:   code_of = dispatch_pkg::OP_RECEIVE;
      dispatch_pkg::ST_TRX_WAIT,
      dispatch_pkg::ST_TRX_SEND:  code_of = dispatch_pkg::OP_TRANSCV;
      dispatch_pkg::ST_AUTH:      code_of = dispatch_pkg::OP_AUTH;
      default:                    code_of = dispatch_pkg::OP_IDLE;
    endcase
  endfunction

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    if (!amapped_reg) begin
      rd_byte = 8'h00;
    end else if (aidx_reg == dispatch_pkg::IDX_OPERATION_SELECT) begin
      rd_byte = {3'b000, power_down_reg, code_of(state_reg)};
    end else if (aidx_reg == dispatch_pkg::IDX_FIFO_DATA) begin
      rd_byte = fifo_mem[rd_ptr_reg];
    end else if (aidx_reg == dispatch_pkg::IDX_FIFO_LEVEL) begin
      rd_byte = {1'b0, count_reg};
    end else if (aidx_reg == dispatch_pkg::IDX_FRAME_BIT_SETUP) begin
      rd_byte = {kick_reg, 4'h0, last_bits_reg};
    end else if (aidx_reg == dispatch_pkg::IDX_CHECKSUM_RESULT) begin
      rd_byte = checksum_reg[7:0];
    end else if (aidx_reg == dispatch_pkg::IDX_SELF_TEST_CTRL) begin
      rd_byte = {4'h0, self_test_reg};
    end else if (aidx_reg == dispatch_pkg::IDX_PROBE_SELECT) begin
      rd_byte = probe_sel_reg;
    end else if (aidx_reg == dispatch_pkg::IDX_TEST_DAC_ONE) begin
      rd_byte = {2'b00, dac_one_reg};
    end else if (aidx_reg == dispatch_pkg::IDX_TEST_DAC_TWO) begin
      rd_byte = {2'b00, dac_two_reg};
    end else if (aidx_reg == dispatch_pkg::IDX_ADC_IQ_SNAPSHOT) begin
      rd_byte = adc_sync_reg;
    end else if (aidx_reg[5:2] == 4'hf) begin
      rd_byte = factory_reg[aidx_reg[1:0]];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

  // ==========================================================
  // FIFO with one push and one pop port; the command datapath has
  // priority, and host data reads and writes are blocked during authentication.
  logic       dev_push;
  logic       dev_pop;
  logic [7:0] dev_data;
  logic       host_fifo;
  logic       push;
  logic       pop;
  logic       fifo_empty;
  logic       fifo_full;
  logic       flush;
  logic [7:0] head;

  assign fifo_empty = (count_reg == 7'd0);
  assign fifo_full  = (count_reg == 7'd64);
  assign head       = fifo_mem[rd_ptr_reg];
  assign host_fifo  = amapped_reg & (aidx_reg == dispatch_pkg::IDX_FIFO_DATA)
                      & (state_reg != dispatch_pkg::ST_AUTH);
  assign push  = dev_push | (host_wr & host_fifo & ~fifo_full);
  assign pop   = dev_pop | (host_rd & host_fifo & ~fifo_empty);
  assign flush = host_wr & (aidx_reg == dispatch_pkg::IDX_FIFO_LEVEL)
                 & hwdata[dispatch_pkg::POS_FLUSH];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      fifo_mem[wr_ptr_reg] <= dev_push ? dev_data : hwdata[7:0];
    end
  end

  // Command start never touches the pointers.
  always_ff @(posedge clk_sys) begin
    if (clr || flush) begin
      wr_ptr_reg <= 6'h00;
      rd_ptr_reg <= 6'h00;
      count_reg  <= 7'd0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + 6'(push);
      rd_ptr_reg <= rd_ptr_reg + 6'(pop);
      count_reg  <= count_reg + 7'(push) - 7'(pop);
    end
  end

  // ==========================================================
  // Command state machine.
  logic cmd_write;
  logic last_idx;
  dispatch_pkg::op_state_t start_state;

  assign cmd_write = host_wr
                     & (aidx_reg == dispatch_pkg::IDX_OPERATION_SELECT);

  always_comb begin
    case (new_cmd)
      dispatch_pkg::OP_MEM:      start_state = fifo_empty ?
        dispatch_pkg::ST_MEM_OUT : dispatch_pkg::ST_MEM_IN;
      dispatch_pkg::OP_RANDOM:   start_state = dispatch_pkg::ST_RANDOM;
      dispatch_pkg::OP_CHECKSUM: start_state =
        (self_test_reg == dispatch_pkg::SELF_TEST_ARMED) ?
        dispatch_pkg::ST_SELF_TEST : dispatch_pkg::ST_CHECKSUM;
      dispatch_pkg::OP_TRANSMIT: start_state = dispatch_pkg::ST_TRANSMIT;
      dispatch_pkg::OP_RECEIVE:  start_state = dispatch_pkg::ST_RECEIVE;
      dispatch_pkg::OP_TRANSCV:  start_state = dispatch_pkg::ST_TRX_WAIT;
      dispatch_pkg::OP_AUTH:     start_state = dispatch_pkg::ST_AUTH;
      default:                   start_state = dispatch_pkg::ST_IDLE;
    endcase
  end

  // Stream states read the FIFO head from their first cycle.
  always_comb begin
    dev_push = 1'b0;
    dev_pop  = 1'b0;
    dev_data = 8'h00;
    case (state_reg)
      dispatch_pkg::ST_MEM_IN,
      dispatch_pkg::ST_CHECKSUM,
      dispatch_pkg::ST_TRANSMIT,
      dispatch_pkg::ST_TRX_SEND: begin
        dev_pop = ~fifo_empty;
      end
      dispatch_pkg::ST_AUTH: begin
        dev_pop = ~fifo_empty & (idx_reg != dispatch_pkg::AUTH_ARG_BYTES);
      end
      dispatch_pkg::ST_MEM_OUT: begin
        dev_push = ~fifo_full;
        dev_data = buffer_mem[idx_reg];
      end
      dispatch_pkg::ST_SELF_TEST: begin
        dev_push = ~fifo_full;
        dev_data = checksum_reg[7:0];
      end
      dispatch_pkg::ST_RECEIVE: begin
        dev_push = rf_rx_valid & ~fifo_full;
        dev_data = rf_rx_byte;
      end
      default: begin
        dev_push = 1'b0;
      end
    endcase
  end

  assign last_idx = (idx_reg == dispatch_pkg::MEM_BYTES - 5'd1);

  always_ff @(posedge clk_sys) begin
    if (clr) begin
      state_reg <= dispatch_pkg::ST_IDLE;
      idx_reg   <= 5'd0;
    end else if (cmd_write && new_cmd != dispatch_pkg::OP_KEEP) begin
      state_reg <= start_state;
      idx_reg   <= 5'd0;
    end else begin
      case (state_reg)
        dispatch_pkg::ST_MEM_IN,
        dispatch_pkg::ST_MEM_OUT: begin
          if (dev_pop || dev_push) begin
            idx_reg <= idx_reg + 5'd1;
            if (last_idx) begin
              state_reg <= dispatch_pkg::ST_IDLE;
            end
          end
        end
        dispatch_pkg::ST_RANDOM: begin
          idx_reg <= idx_reg + 5'd1;
          if (idx_reg == dispatch_pkg::RANDOM_BYTES - 5'd1) begin
            state_reg <= dispatch_pkg::ST_IDLE;
          end
        end
        dispatch_pkg::ST_SELF_TEST: begin
          if (dev_push) begin
            state_reg <= dispatch_pkg::ST_IDLE;
          end
        end
        // The checksum state has no exit of its own.
        dispatch_pkg::ST_CHECKSUM: begin
          state_reg <= dispatch_pkg::ST_CHECKSUM;
        end
        dispatch_pkg::ST_TRANSMIT: begin
          if (fifo_empty) begin
            state_reg <= dispatch_pkg::ST_IDLE;
          end
        end
        dispatch_pkg::ST_TRX_WAIT: begin
          if (kick_reg) begin
            state_reg <= dispatch_pkg::ST_TRX_SEND;
          end
        end
        dispatch_pkg::ST_TRX_SEND: begin
          if (fifo_empty) begin
            state_reg <= dispatch_pkg::ST_RECEIVE;
          end
        end
        dispatch_pkg::ST_RECEIVE: begin
          if (rf_rx_end) begin
            state_reg <= dispatch_pkg::ST_IDLE;
          end
        end
        dispatch_pkg::ST_AUTH: begin
          if (dev_pop) begin
            idx_reg <= idx_reg + 5'd1;
          end
          if (card_auth_done && idx_reg == dispatch_pkg::AUTH_ARG_BYTES) begin
            state_reg <= dispatch_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= dispatch_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Internal buffer survives soft reset, so it has no reset at all.
  always_ff @(posedge clk_sys) begin
    if (state_reg == dispatch_pkg::ST_MEM_IN && dev_pop) begin
      buffer_mem[idx_reg] <= head;
    end else if (state_reg == dispatch_pkg::ST_RANDOM) begin
      buffer_mem[idx_reg] <= lfsr_reg[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lfsr_reg <= dispatch_pkg::RANDOM_SEED;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0],
                   lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    end
  end

  function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ dispatch_pkg::CHECKSUM_POLY) : (r << 1);
    end
    crc_step = r;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (clr) begin
      checksum_reg <= dispatch_pkg::CHECKSUM_PRESET;
    end else if (cmd_write && new_cmd == dispatch_pkg::OP_CHECKSUM) begin
      checksum_reg <= dispatch_pkg::CHECKSUM_PRESET;
    end else if (state_reg == dispatch_pkg::ST_CHECKSUM && dev_pop) begin
      checksum_reg <= crc_step(checksum_reg, head);
    end
  end

  // ==========================================================
  // Software-visible control registers.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= cmd_write & (new_cmd == dispatch_pkg::OP_SW_RESET);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clr) begin
      power_down_reg <= 1'b0;
      last_bits_reg  <= dispatch_pkg::RST_LAST_BITS;
      self_test_reg  <= dispatch_pkg::RST_SELF_TEST;
      probe_sel_reg  <= dispatch_pkg::RST_PROBE_SEL;
      dac_one_reg    <= dispatch_pkg::RST_TEST_DAC;
      dac_two_reg    <= dispatch_pkg::RST_TEST_DAC;
      factory_reg[0] <= dispatch_pkg::RST_FACTORY_A;
      factory_reg[1] <= dispatch_pkg::RST_FACTORY_B;
      factory_reg[2] <= dispatch_pkg::RST_FACTORY_C;
      factory_reg[3] <= dispatch_pkg::RST_FACTORY_D;
    end else if (host_wr) begin
      if (aidx_reg == dispatch_pkg::IDX_OPERATION_SELECT) begin
        power_down_reg <= hwdata[dispatch_pkg::POS_POWER_DOWN];
      end else if (aidx_reg == dispatch_pkg::IDX_FRAME_BIT_SETUP) begin
        last_bits_reg <= hwdata[2:0];
      end else if (aidx_reg == dispatch_pkg::IDX_SELF_TEST_CTRL) begin
        self_test_reg <= hwdata[3:0];
      end else if (aidx_reg == dispatch_pkg::IDX_PROBE_SELECT) begin
        probe_sel_reg <= hwdata[7:0];
      end else if (aidx_reg == dispatch_pkg::IDX_TEST_DAC_ONE) begin
        dac_one_reg <= hwdata[5:0];
      end else if (aidx_reg == dispatch_pkg::IDX_TEST_DAC_TWO) begin
        dac_two_reg <= hwdata[5:0];
      end else if (aidx_reg[5:2] == 4'hf) begin
        factory_reg[aidx_reg[1:0]] <= hwdata[7:0];
      end
    end
  end

  // The kick is consumed when the send phase starts; a host set in
  // that same cycle wins so a kick is never lost.
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      kick_reg <= 1'b0;
    end else if (host_wr && aidx_reg == dispatch_pkg::IDX_FRAME_BIT_SETUP
                 && hwdata[dispatch_pkg::POS_KICK]) begin
      kick_reg <= 1'b1;
    end else if (state_reg == dispatch_pkg::ST_TRX_WAIT) begin
      kick_reg <= 1'b0;
    end
  end

  // ==========================================================
  // ADC pins are asynchronous; the snapshot is two stages deep.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      adc_meta_reg <= 8'h00;
      adc_sync_reg <= 8'h00;
    end else begin
      adc_meta_reg <= {adc_i_pin, adc_q_pin};
      adc_sync_reg <= adc_meta_reg;
    end
  end

  // ==========================================================
  // Registered outputs toward the analog, RF and authentication blocks.
  always_ff @(posedge clk_sys) begin
    if (clr) begin
      rf_tx_byte                 <= 8'h00;
      rf_tx_strobe               <= 1'b0;
      rf_rx_enable               <= 1'b0;
      card_auth_active           <= 1'b0;
      probe_dac_first_value      <= dispatch_pkg::RST_TEST_DAC;
      probe_dac_second_value     <= dispatch_pkg::RST_TEST_DAC;
      probe_pin_first_dac_route  <= 1'b0;
      probe_pin_second_dac_route <= 1'b0;
      power_down                 <= 1'b0;
    end else begin
      rf_tx_strobe <= dev_pop & ((state_reg == dispatch_pkg::ST_TRANSMIT)
                      | (state_reg == dispatch_pkg::ST_TRX_SEND));
      if (dev_pop) begin
        rf_tx_byte <= head;
      end
      rf_rx_enable     <= (state_reg == dispatch_pkg::ST_RECEIVE);
      card_auth_active <= (state_reg == dispatch_pkg::ST_AUTH)
                          & (idx_reg == dispatch_pkg::AUTH_ARG_BYTES);
      probe_dac_first_value      <= dac_one_reg;
      probe_dac_second_value     <= dac_two_reg;
      probe_pin_first_dac_route  <=
        (probe_sel_reg[7:4] == dispatch_pkg::PROBE_SEL_DAC);
      probe_pin_second_dac_route <=
        (probe_sel_reg[3:0] == dispatch_pkg::PROBE_SEL_DAC);
      power_down <= power_down_reg;
    end
  end

endmodule

// ### rtl/dispatch_pkg.sv
// Constants shared by the reader command dispatcher.
package dispatch_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index).
  localparam logic [5:0] IDX_OPERATION_SELECT = 6'h01;
  localparam logic [5:0] IDX_FIFO_DATA        = 6'h09;
  localparam logic [5:0] IDX_FIFO_LEVEL       = 6'h0a;
  localparam logic [5:0] IDX_FRAME_BIT_SETUP  = 6'h0d;
  localparam logic [5:0] IDX_CHECKSUM_RESULT  = 6'h21;
  localparam logic [5:0] IDX_SELF_TEST_CTRL   = 6'h36;
  localparam logic [5:0] IDX_PROBE_SELECT     = 6'h38;
  localparam logic [5:0] IDX_TEST_DAC_ONE     = 6'h39;
  localparam logic [5:0] IDX_TEST_DAC_TWO     = 6'h3a;
  localparam logic [5:0] IDX_ADC_IQ_SNAPSHOT  = 6'h3b;
  localparam logic [5:0] IDX_FACTORY_A        = 6'h3c;
  localparam logic [5:0] IDX_FACTORY_B        = 6'h3d;
  localparam logic [5:0] IDX_FACTORY_C        = 6'h3e;
  localparam logic [5:0] IDX_FACTORY_D        = 6'h3f;

  // ==========================================================
  // Reset values and field positions.
  localparam logic [7:0] RST_FACTORY_A  = 8'hff;
  localparam logic [7:0] RST_FACTORY_B  = 8'h00;
  localparam logic [7:0] RST_FACTORY_C  = 8'h03;
  localparam logic [7:0] RST_FACTORY_D  = 8'h00;
  localparam logic [5:0] RST_TEST_DAC   = 6'h00;
  localparam logic [7:0] RST_PROBE_SEL  = 8'h00;
  localparam logic [3:0] RST_SELF_TEST  = 4'h0;
  localparam logic [2:0] RST_LAST_BITS  = 3'h0;
  localparam int         POS_POWER_DOWN = 4;
  localparam int         POS_KICK       = 7;
  localparam int         POS_FLUSH      = 7;

  // ==========================================================
  // Command codes and command constants.
  localparam logic [3:0] OP_IDLE     = 4'h0;
  localparam logic [3:0] OP_MEM      = 4'h1;
  localparam logic [3:0] OP_RANDOM   = 4'h2;
  localparam logic [3:0] OP_CHECKSUM = 4'h3;
  localparam logic [3:0] OP_TRANSMIT = 4'h4;
  localparam logic [3:0] OP_KEEP     = 4'h7;
  localparam logic [3:0] OP_RECEIVE  = 4'h8;
  localparam logic [3:0] OP_TRANSCV  = 4'hc;
  localparam logic [3:0] OP_AUTH     = 4'he;
  localparam logic [3:0] OP_SW_RESET = 4'hf;
  localparam logic [3:0] SELF_TEST_ARMED = 4'h9;
  localparam logic [3:0] PROBE_SEL_DAC   = 4'h1;
  localparam logic [4:0] MEM_BYTES       = 5'd25;
  localparam logic [4:0] RANDOM_BYTES    = 5'd10;
  localparam logic [4:0] AUTH_ARG_BYTES  = 5'd12;
  localparam logic [15:0] CHECKSUM_PRESET = 16'h6363;
  localparam logic [15:0] CHECKSUM_POLY   = 16'h1021;
  localparam logic [15:0] RANDOM_SEED     = 16'hace1;
  localparam int          FIFO_DEPTH      = 64;

  typedef enum logic [10:0] {
    ST_IDLE      = 11'b000_0000_0001,
    ST_MEM_IN    = 11'b000_0000_0010,
    ST_MEM_OUT   = 11'b000_0000_0100,
    ST_RANDOM    = 11'b000_0000_1000,
    ST_CHECKSUM  = 11'b000_0001_0000,
    ST_SELF_TEST = 11'b000_0010_0000,
    ST_TRANSMIT  = 11'b000_0100_0000,
    ST_TRX_WAIT  = 11'b000_1000_0000,
    ST_TRX_SEND  = 11'b001_0000_0000,
    ST_RECEIVE   = 11'b010_0000_0000,
    ST_AUTH      = 11'b100_0000_0000
  } op_state_t;

endpackage

// ### testbench/dispatch_monitor.sv
// Concurrent checks on the ports of the reader command dispatcher.
`timescale 1ns/100ps
module dispatch_monitor (
  // Clock, reset and register bus
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  // Device side
  input wire logic        rf_rx_enable,
  input wire logic        rf_rx_end,
  input wire logic        card_auth_active,
  input wire logic        card_auth_done,
  input wire logic [5:0]  probe_dac_first_value,
  input wire logic [5:0]  probe_dac_second_value,
  input wire logic        probe_pin_first_dac_route,
  input wire logic        power_down
);
  logic        wdp;
  logic [7:0]  wa;
  logic [31:0] wd;
  default clocking dclk @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // ==========================================================
  // Write data phase tracking, so checks see the committed word.
  always_ff @(posedge clk_sys) begin
    if (reset) wdp <= 1'b0;
    else if (hready) wdp <= hsel && htrans[1] && hwrite;
  end
  always_ff @(posedge clk_sys) begin
    if (hready && hsel && htrans[1]) wa <= haddr[7:0];
    if (hready && wdp) wd <= hwdata;
  end
  // ==========================================================
  // Properties.
  AST_READ_WAIT: assert property (hready && hsel && htrans[1] && !hwrite
    |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  AST_DAC_FIRST: assert property (
    wdp && hready && wa == 8'he4 |-> ##[1:2] probe_dac_first_value == wd[5:0])
    else $error("first dac value not applied");
  AST_DAC_SECOND: assert property (
    wdp && hready && wa == 8'he8 |-> ##[1:2] probe_dac_second_value == wd[5:0])
    else $error("second dac value not applied");
  AST_ROUTE_FIRST: assert property (
    wdp && hready && wa == 8'he0
    |-> ##[1:2] probe_pin_first_dac_route == (wd[7:4] == 4'h1))
    else $error("first probe route wrong");
  AST_POWER_BIT: assert property (
    wdp && hready && wa == 8'h04 && hwdata[3:0] != 4'hf
    |-> ##[1:2] power_down == wd[4])
    else $error("power down bit not applied");
  AST_CANCEL: assert property (
    wdp && hready && wa == 8'h04 && hwdata[3:0] == 4'h0
    |-> ##[1:3] !rf_rx_enable && !card_auth_active)
    else $error("idle code did not cancel");
  AST_RX_END: assert property (
    rf_rx_enable && rf_rx_end |-> ##[1:2] !rf_rx_enable)
    else $error("receiver stayed on after frame end");
  AST_AUTH_END: assert property (
    card_auth_active && card_auth_done |-> ##[1:2] !card_auth_active)
    else $error("authentication did not end");
endmodule
bind reader_command_dispatcher dispatch_monitor mon_u (.clk_sys, .reset,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout,
  .rf_rx_enable, .rf_rx_end, .card_auth_active, .card_auth_done,
  .probe_dac_first_value, .probe_dac_second_value,
  .probe_pin_first_dac_route, .power_down);

// ### testbench/field_model.sv
// Far-side model: RF field, card and ADC pin levels.
`timescale 1ns/100ps
module field_model (
  // Device outputs
  input  wire logic       clk_sys,
  input  wire logic [7:0] rf_tx_byte,
  input  wire logic       rf_tx_strobe,
  input  wire logic       rf_rx_enable,
  input  wire logic       card_auth_active,
  // Device inputs
  output logic      [7:0] rf_rx_byte,
  output logic            rf_rx_valid,
  output logic            rf_rx_end,
  output logic            card_auth_done,
  output logic      [3:0] adc_i_pin,
  output logic      [3:0] adc_q_pin,
  // Observation
  output int              tx_count,
  output logic      [7:0] last_tx
);
  int step = 0;
  int auth_wait = 0;
  assign adc_i_pin = 4'ha;
  assign adc_q_pin = 4'h3;
  initial begin
    {rf_rx_byte, rf_rx_valid, rf_rx_end, card_auth_done} = 11'h0;
    tx_count = 0;
    last_tx = 8'h00;
  end
  always @(posedge clk_sys) begin
    if (rf_tx_strobe) begin
      tx_count <= tx_count + 1;
      last_tx <= rf_tx_byte;
    end
    // An idle data line toggles so a stale byte never passes for data.
    rf_rx_byte <= ~rf_rx_byte;
    rf_rx_valid <= 1'b0;
    step <= rf_rx_enable ? step + 1 : 0;
    if (step == 3 || step == 5) begin
      rf_rx_valid <= 1'b1;
      rf_rx_byte <= 8'(8'hc0 + step);
    end
    rf_rx_end <= (step == 7);
    // The card answers slowly, some cycles after the arguments are in.
    auth_wait <= card_auth_active ? auth_wait + 1 : 0;
    card_auth_done <= (auth_wait == 6);
  end
endmodule

// ### testbench/tb_top.sv
// Self-checking testbench for the reader command dispatcher.
`timescale 1ns/100ps
module tb_top;
  logic clk_sys = 1'b0, reset = 1'b1, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'b00;
  logic [7:0] rf_tx_byte, rf_rx_byte, last_tx;
  logic rf_tx_strobe, rf_rx_enable, rf_rx_valid, rf_rx_end, power_down;
  logic card_auth_active, card_auth_done;
  logic probe_pin_first_dac_route, probe_pin_second_dac_route;
  logic [3:0] adc_i_pin, adc_q_pin;
  logic [5:0] probe_dac_first_value, probe_dac_second_value;
  int tx_count, miscompares = 0, cmp_count = 0;
  always #10 clk_sys = ~clk_sys;
  reader_command_dispatcher dut_u (.clk_sys, .reset, .hsel(1'b1), .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .rf_tx_byte, .rf_tx_strobe, .rf_rx_enable,
    .rf_rx_byte, .rf_rx_valid, .rf_rx_end, .card_auth_active,
    .card_auth_done, .adc_i_pin, .adc_q_pin, .probe_dac_first_value,
    .probe_dac_second_value, .probe_pin_first_dac_route,
    .probe_pin_second_dac_route, .power_down);
  field_model fm_u (.clk_sys, .rf_tx_byte, .rf_tx_strobe, .rf_rx_enable,
    .card_auth_active, .rf_rx_byte, .rf_rx_valid, .rf_rx_end,
    .card_auth_done, .adc_i_pin, .adc_q_pin, .tx_count, .last_tx);
  // ==========================================================
  // Bus tasks and comparison.
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task xfer(input logic w, input logic [5:0] i, input logic [7:0] d);
    haddr <= {24'h0, i, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task wr(input logic [5:0] i, input logic [7:0] d);
    xfer(1'b1, i, d);
  endtask
  task rd(input logic [5:0] i, input logic [7:0] e);
    xfer(1'b0, i, 8'h00);
    chk(r, {24'h0, e});
  endtask
  task fill(input int n, input logic [7:0] b);
    for (int k = 0; k < n; k++) wr(6'h09, 8'(b + k));
  endtask
  task run(input logic [7:0] c);
    wr(6'h01, c);
    do xfer(1'b0, 6'h01, 8'h00); while (r[3:0] !== 4'h0);
  endtask
  task finish_test;
    $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    finish_test;
  end
  // ==========================================================
  // Test sequence.
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd(6'h3c, 8'hff);
    rd(6'h3d, 8'h00);
    rd(6'h3e, 8'h03);
    rd(6'h3f, 8'h00);
    rd(6'h30, 8'h00);
    wr(6'h39, 8'h2a);
    wr(6'h3a, 8'h15);
    wr(6'h38, 8'h11);
    rd(6'h3a, 8'h15);
    chk(32'(probe_pin_second_dac_route), 32'h1);
    chk(32'(probe_dac_first_value), 32'h2a);
    rd(6'h3b, 8'ha3);
    chk(32'(hresp), 32'h0);
    fill(3, 8'h40);
    wr(6'h01, 8'h00);
    rd(6'h0a, 8'h03);
    run(8'h04);
    chk(32'(tx_count), 32'h3);
    chk(32'(last_tx), 32'h42);
    rd(6'h0a, 8'h00);
    fill(2, 8'h50);
    wr(6'h01, 8'h03);
    wr(6'h01, 8'h17);
    rd(6'h01, 8'h13);
    wr(6'h01, 8'h08);
    wr(6'h01, 8'h00);
    rd(6'h01, 8'h00);
    wr(6'h36, 8'h09);
    run(8'h03);
    rd(6'h0a, 8'h01);
    wr(6'h36, 8'h00);
    wr(6'h0a, 8'h80);
    fill(1, 8'h77);
    wr(6'h01, 8'h0c);
    repeat (10) @(posedge clk_sys);
    chk(32'(tx_count), 32'h3);
    wr(6'h0d, 8'h80);
    do xfer(1'b0, 6'h01, 8'h00); while (r[3:0] !== 4'h0);
    chk(32'(last_tx), 32'h77);
    rd(6'h09, 8'hc3);
    rd(6'h09, 8'hc5);
    fill(11, 8'h00);
    wr(6'h01, 8'h0e);
    repeat (20) @(posedge clk_sys);
    chk(32'(card_auth_active), 32'h0);
    wr(6'h01, 8'h00);
    fill(12, 8'h60);
    run(8'h0e);
    chk(32'(card_auth_active), 32'h0);
    wr(6'h0a, 8'h80);
    fill(25, 8'h20);
    run(8'h01);
    rd(6'h0a, 8'h00);
    run(8'h02);
    run(8'h01);
    rd(6'h0a, 8'h19);
    for (int k = 0; k < 10; k++) xfer(1'b0, 6'h09, 8'h00);
    rd(6'h09, 8'h2a);
    wr(6'h3c, 8'h55);
    rd(6'h3c, 8'h55);
    wr(6'h01, 8'h0f);
    repeat (3) @(posedge clk_sys);
    rd(6'h3c, 8'hff);
    rd(6'h0a, 8'h00);
    run(8'h01);
    rd(6'h0a, 8'h19);
    repeat (10) xfer(1'b0, 6'h09, 8'h00);
    rd(6'h09, 8'h2a);
    finish_test;
  end
endmodule
